// ===== rtl/oec_ctrl.sv
// oec_ctrl: output enable, off-state programming, set-point checks and power-up save control
// assumes synchronous inputs on ref_clk and a nonvolatile store that answers in one cycle
//
// Behaviour
// - save command stores selected interface or serial group for power-up.
// - saving limits stores voltage, current limits and protection maxima.
// - saving output group stores on/off state and operating mode.
// - output command true enables, false disables the output.
// - default power-up has output and analog control enabled.
// - voltage source off: save values, zero voltage, low current protection.
// - current source off: save values, zero current, low voltage protection.
// - output on restores voltage and current saved at turn-off.
// - while off, set-point reads report saved values.
// - output state reads 0 when disabled, 1 when enabled.
// - pin configuration defaults high-disables, saved with interface group.
// - high-enables: pin 1 enables, pin 0 disables.
// - low-enables: pin 0 enables, pin 1 disables.
// - level-enables settings ignore output on and off commands.
// - high-disables: pin 1 forces off; pin 0 allows command enable.
// - low-disables: pin 0 forces off; pin 1 allows command enable.
// - latched mode: pin 0 for 100 us turns off; only command re-enables.
// - disabled pin setting ignores the remote pin.
// - pin configuration reads back the selected setting.
// - load type selects off behaviour and reads back.
// - current above rated ceiling rejected, error -222 posted.
// - voltage mode current set also sets both current protections.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module oec_ctrl
  import oec_pkg::*;
#(
  parameter int PULSE_CYC = OEC_PULSE_CYC,
  parameter logic DEF_OUT_ON = 1'b1,
  parameter logic DEF_ANALOG_EN = 1'b1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // remote on/off pin, 1 = high or open
  input wire logic remote_pin,
  // nonvolatile store
  input wire logic [OEC_NGRP-1:0] nv_valid,
  input wire oec_intf_grp_t nv_intf,
  input wire oec_ser_grp_t nv_ser,
  input wire oec_lim_grp_t nv_lim,
  input wire oec_out_grp_t nv_out,
  output logic [OEC_NGRP-1:0] nv_wr,
  output oec_intf_grp_t nv_intf_w,
  output oec_ser_grp_t nv_ser_w,
  output oec_lim_grp_t nv_lim_w,
  output oec_out_grp_t nv_out_w,
  // output stage
  output logic out_en,
  output logic analog_en,
  output logic [15:0] vprog,
  output logic [15:0] iprog,
  output logic [15:0] iprot_pos,
  output logic [15:0] iprot_neg,
  output logic [15:0] vprot,
  output logic ready
);

  // ****************************************
  // state
  // ****************************************
  oec_state_t st_q;
  logic out_on_q, cur_mode_q, analog_q;
  oec_pin_cfg_t pin_cfg_q;
  oec_load_t load_q;
  logic [4:0] bus_addr_q;
  logic [7:0] sys_set_q;
  oec_ser_grp_t ser_q;
  oec_lim_grp_t lim_q;
  logic [15:0] vset_q, iset_q, vsave_q, isave_q;
  logic [15:0] vprog_q, iprog_q, iprot_p_q, iprot_n_q, vprot_q;
  logic [15:0] err_q;
  logic [15:0] low_cnt_q;
  logic [OEC_NGRP-1:0] nv_wr_q;
  logic [31:0] rdata_q;

  wire logic run = (st_q == OEC_ST_RUN);
  wire logic wr_cmd = run && reg_wr && (reg_addr == OEC_CMD_OFS);
  wire logic [3:0] cmd = reg_wdata[3:0];
  wire logic level_en_mode = (pin_cfg_q == OEC_PIN_HIGH_EN) || (pin_cfg_q == OEC_PIN_LOW_EN);
  wire logic cmd_on = wr_cmd && (cmd == OEC_CMD_OUT_ON) && !level_en_mode;
  wire logic cmd_off = wr_cmd && (cmd == OEC_CMD_OUT_OFF) && !level_en_mode;
  wire logic latch_trip = (pin_cfg_q == OEC_PIN_LATCH) && (low_cnt_q == 16'(PULSE_CYC - 1)) && !remote_pin;

  // ****************************************
  // remote pin gating
  // ****************************************
  logic pin_force_off, pin_level_on;
  always_comb begin
    pin_force_off = 1'b0;
    pin_level_on = 1'b0;
    unique case (pin_cfg_q)
      OEC_PIN_HIGH_DIS: pin_force_off = remote_pin;
      OEC_PIN_HIGH_EN: pin_level_on = remote_pin;
      OEC_PIN_LOW_EN: pin_level_on = !remote_pin;
      OEC_PIN_LOW_DIS: pin_force_off = !remote_pin;
      default: ;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_q <= 16'h0000;
    end else if (pin_cfg_q != OEC_PIN_LATCH || remote_pin) begin
      low_cnt_q <= 16'h0000;
    end else if (low_cnt_q != 16'(PULSE_CYC - 1)) begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end

  // ****************************************
  // sequencer: load saved groups, then run
  // ****************************************
  // load before acting
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= OEC_ST_LOAD;
    end else begin
      unique case (st_q)
        OEC_ST_LOAD: st_q <= OEC_ST_RUN;
        OEC_ST_RUN: st_q <= OEC_ST_RUN;
        default: st_q <= OEC_ST_RUN;
      endcase
    end
  end

  // ****************************************
  // configuration groups
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_cfg_q <= OEC_PIN_HIGH_DIS;
      bus_addr_q <= 5'h00;
      sys_set_q <= 8'h00;
      ser_q <= '0;
      lim_q <= {OEC_DEF_LIMIT, OEC_DEF_LIMIT, OEC_DEF_LIMIT, OEC_DEF_LIMIT};
      load_q <= OEC_LOAD_RESISTIVE;
      analog_q <= 1'b0;
    end else if (st_q == OEC_ST_LOAD) begin
      analog_q <= DEF_ANALOG_EN;
      if (nv_valid[OEC_GRP_INT]) begin
        pin_cfg_q <= oec_pin_cfg_t'(nv_intf.pin_cfg);
        bus_addr_q <= nv_intf.bus_addr;
        sys_set_q <= nv_intf.sys_set;
      end
      if (nv_valid[OEC_GRP_SER]) begin
        ser_q <= nv_ser;
      end
      if (nv_valid[OEC_GRP_LIM]) begin
        lim_q <= nv_lim;
      end
    end else if (reg_wr && reg_addr == OEC_CFG_OFS) begin
      if (reg_wdata[2:0] <= 3'b101) begin
        pin_cfg_q <= oec_pin_cfg_t'(reg_wdata[2:0]);
      end
      if (reg_wdata[5:4] != 2'b11) begin
        load_q <= oec_load_t'(reg_wdata[5:4]);
      end
      bus_addr_q <= reg_wdata[12:8];
      analog_q <= reg_wdata[7];
    end else if (reg_wr && reg_addr == OEC_LIM_OFS) begin
      lim_q.ilim <= reg_wdata[15:0];
      lim_q.vlim <= reg_wdata[31:16];
    end
  end

  // ****************************************
  // output state and mode
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_on_q <= 1'b0;
      cur_mode_q <= 1'b0;
    end else if (st_q == OEC_ST_LOAD) begin
      out_on_q <= nv_valid[OEC_GRP_OUT] ? nv_out.out_on : DEF_OUT_ON;
      cur_mode_q <= nv_valid[OEC_GRP_OUT] ? nv_out.cur_mode : 1'b0;
    end else begin
      if (reg_wr && reg_addr == OEC_CFG_OFS) begin
        cur_mode_q <= reg_wdata[3];
      end
      if (latch_trip) begin
        out_on_q <= 1'b0;
      end else if (cmd_on) begin
        out_on_q <= 1'b1;
      end else if (cmd_off) begin
        out_on_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // set-points, saved values and protections
  // ****************************************
  wire logic wr_iset = run && reg_wr && (reg_addr == OEC_ISET_OFS);
  wire logic i_bad = reg_wdata[15:0] > OEC_RATED_CURRENT_CEILING;
  // a trip saves too, so a later on command never restores stale values
  wire logic going_off = (cmd_off || latch_trip) && out_on_q;
  // active loads are only disabled; zeroing the set-points could fight the load
  wire logic zero_off = cmd_off && out_on_q && (load_q != OEC_LOAD_ACTIVE);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vset_q <= 16'h0000;
      iset_q <= 16'h0000;
      vsave_q <= 16'h0000;
      isave_q <= 16'h0000;
      vprog_q <= 16'h0000;
      iprog_q <= 16'h0000;
      iprot_p_q <= OEC_DEF_LIMIT;
      iprot_n_q <= OEC_DEF_LIMIT;
      vprot_q <= OEC_DEF_LIMIT;
    end else if (going_off) begin
      vsave_q <= vset_q;
      isave_q <= iset_q;
      if (zero_off && !cur_mode_q) begin
        vprog_q <= 16'h0000;
        iprot_p_q <= OEC_LOW_PROT;
        iprot_n_q <= OEC_LOW_PROT;
      end else if (zero_off) begin
        iprog_q <= 16'h0000;
        vprot_q <= OEC_LOW_PROT;
      end
    end else if (cmd_on && !out_on_q) begin
      vprog_q <= vsave_q;
      iprog_q <= isave_q;
      vset_q <= vsave_q;
      iset_q <= isave_q;
      iprot_p_q <= cur_mode_q ? lim_q.iprot_max : isave_q;
      iprot_n_q <= cur_mode_q ? lim_q.iprot_max : isave_q;
      vprot_q <= lim_q.vprot_max;
    end else if (run && reg_wr && reg_addr == OEC_VSET_OFS) begin
      vset_q <= reg_wdata[15:0];
      if (out_on_q) begin
        vprog_q <= reg_wdata[15:0];
      end else begin
        vsave_q <= reg_wdata[15:0];
      end
    end else if (wr_iset && !i_bad) begin
      iset_q <= reg_wdata[15:0];
      if (out_on_q) begin
        iprog_q <= reg_wdata[15:0];
      end else begin
        isave_q <= reg_wdata[15:0];
      end
      if (!cur_mode_q) begin
        iprot_p_q <= reg_wdata[15:0];
        iprot_n_q <= reg_wdata[15:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= 16'h0000;
    end else if (wr_iset && i_bad) begin
      err_q <= OEC_ERR_RANGE;
    end else if (run && reg_rd && reg_addr == OEC_ERR_OFS) begin
      err_q <= 16'h0000;
    end
  end

  // ****************************************
  // save for power-up
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nv_wr_q <= '0;
    end else if (wr_cmd && cmd == OEC_CMD_SAVE) begin
      nv_wr_q <= reg_wdata[8 +: OEC_NGRP];
    end else begin
      nv_wr_q <= '0;
    end
  end

  assign nv_intf_w = '{pin_cfg: pin_cfg_q, bus_addr: bus_addr_q, sys_set: sys_set_q};
  assign nv_ser_w = ser_q;
  assign nv_lim_w = lim_q;
  assign nv_out_w = '{out_on: out_on_q, cur_mode: cur_mode_q};
  assign nv_wr = nv_wr_q;

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OEC_CFG_OFS: rdata_q <= {19'h0_0000, bus_addr_q, analog_q, 1'b0, load_q, cur_mode_q, pin_cfg_q};
        OEC_VSET_OFS: rdata_q <= {16'h0000, out_on_q ? vset_q : vsave_q};
        OEC_ISET_OFS: rdata_q <= {16'h0000, out_on_q ? iset_q : isave_q};
        OEC_STAT_OFS: rdata_q <= {29'h0000_0000, run, remote_pin, out_en};
        OEC_VOUT_OFS: rdata_q <= {16'h0000, vprog_q};
        OEC_IOUT_OFS: rdata_q <= {16'h0000, iprog_q};
        OEC_PROT_OFS: rdata_q <= {iprot_n_q, iprot_p_q};
        OEC_LIM_OFS: rdata_q <= {lim_q.vlim, lim_q.ilim};
        OEC_ERR_OFS: rdata_q <= {16'h0000, err_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_q;

  // level-enables modes hand the output wholly to the pin
  assign out_en = run && (level_en_mode ? pin_level_on : (out_on_q && !pin_force_off));
  assign analog_en = analog_q;
  assign vprog = vprog_q;
  assign iprog = iprog_q;
  assign iprot_pos = iprot_p_q;
  assign iprot_neg = iprot_n_q;
  assign vprot = vprot_q;
  assign ready = run;

endmodule : oec_ctrl
`default_nettype wire

// ===== shared/oec_pkg.sv
// oec_pkg: constants, enumerations and carrier structs for the output-enable control block
// assumes a 10 MHz ref_clk and a plain strobe register port
package oec_pkg;

  // ****************************************
  // register offsets (byte addresses, word index = offset / 4)
  // ****************************************
  localparam logic [5:0] OEC_CMD_OFS = 6'h00;
  localparam logic [5:0] OEC_CFG_OFS = 6'h04;
  localparam logic [5:0] OEC_VSET_OFS = 6'h08;
  localparam logic [5:0] OEC_ISET_OFS = 6'h0c;
  localparam logic [5:0] OEC_STAT_OFS = 6'h10;
  localparam logic [5:0] OEC_VOUT_OFS = 6'h14;
  localparam logic [5:0] OEC_IOUT_OFS = 6'h18;
  localparam logic [5:0] OEC_PROT_OFS = 6'h1c;
  localparam logic [5:0] OEC_LIM_OFS = 6'h20;
  localparam logic [5:0] OEC_ERR_OFS = 6'h24;

  // ****************************************
  // command codes written to the command register
  // ****************************************
  localparam logic [3:0] OEC_CMD_OUT_OFF = 4'h1;
  localparam logic [3:0] OEC_CMD_OUT_ON = 4'h2;
  localparam logic [3:0] OEC_CMD_SAVE = 4'h3;

  // ****************************************
  // values and timing
  // ****************************************
  localparam logic [15:0] OEC_LOW_PROT = 16'h0010;
  localparam logic [15:0] OEC_RATED_CURRENT_CEILING = 16'h7fff;
  localparam logic [15:0] OEC_DEF_LIMIT = 16'h7fff;
  // -222 as a 16-bit two's complement code
  localparam logic [15:0] OEC_ERR_RANGE = 16'hff22;
  localparam int OEC_PULSE_US = 100;
  localparam int OEC_CLK_MHZ = 10;
  localparam int OEC_PULSE_CYC = OEC_PULSE_US * OEC_CLK_MHZ;

  typedef enum logic [2:0] {
    OEC_PIN_HIGH_DIS = 3'b000,
    OEC_PIN_HIGH_EN = 3'b001,
    OEC_PIN_LOW_EN = 3'b010,
    OEC_PIN_LOW_DIS = 3'b011,
    OEC_PIN_LATCH = 3'b100,
    OEC_PIN_OFF = 3'b101
  } oec_pin_cfg_t;

  typedef enum logic [1:0] {
    OEC_LOAD_ACTIVE = 2'b00,
    OEC_LOAD_RESISTIVE = 2'b01,
    OEC_LOAD_BATTERY = 2'b10
  } oec_load_t;

  typedef enum logic [1:0] {
    OEC_ST_LOAD = 2'b00,
    OEC_ST_RUN = 2'b01,
    OEC_ST_STORE = 2'b10
  } oec_state_t;

  // setting groups held in nonvolatile storage
  typedef struct packed {
    logic [2:0] pin_cfg;
    logic [4:0] bus_addr;
    logic [7:0] sys_set;
  } oec_intf_grp_t;

  typedef struct packed {
    logic [7:0] link;
    logic [7:0] baud;
    logic pace;
    logic echo;
  } oec_ser_grp_t;

  typedef struct packed {
    logic [15:0] vlim;
    logic [15:0] ilim;
    logic [15:0] vprot_max;
    logic [15:0] iprot_max;
  } oec_lim_grp_t;

  typedef struct packed {
    logic out_on;
    logic cur_mode;
  } oec_out_grp_t;

  // group select bits in the save command / nv valid flags
  localparam int OEC_GRP_INT = 0;
  localparam int OEC_GRP_SER = 1;
  localparam int OEC_GRP_LIM = 2;
  localparam int OEC_GRP_OUT = 3;
  localparam int OEC_NGRP = 4;

endpackage : oec_pkg

// ===== verif/oec_ctrl_monitor.sv
// oec_ctrl_monitor: port assertions for oec_ctrl
// assumes one ref_clk domain; bound into every oec_ctrl
`timescale 1ns/1ns
`default_nettype none
module oec_ctrl_monitor
  import oec_pkg::*;
#(
  parameter int PULSE_CYC = OEC_PULSE_CYC
) (
  // clock, reset and register port
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic ready,
  // pin, store and output
  input wire logic remote_pin,
  input wire logic [OEC_NGRP-1:0] nv_valid,
  input wire oec_intf_grp_t nv_intf,
  input wire logic [OEC_NGRP-1:0] nv_wr,
  input wire logic out_en,
  input wire logic [15:0] iprog
);
  // ********
  // shadow state
  // ********
  logic [2:0] cfg_q;
  logic [3:0] grp_q;
  int lo_q;
  wire cmd_wr = ready && reg_wr && reg_addr == OEC_CMD_OFS;

  // reloads with the design, so a second reset keeps the shadow in step
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= 3'h0;
    end else if (!ready) begin
      cfg_q <= nv_valid[OEC_GRP_INT] ? nv_intf.pin_cfg : 3'h0;
    end else if (reg_wr && reg_addr == OEC_CFG_OFS && reg_wdata[2:0] < 3'h6) begin
      cfg_q <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      grp_q <= 4'h0;
      lo_q <= 0;
    end else begin
      grp_q <= reg_wdata[11:8];
      lo_q <= (cfg_q == OEC_PIN_LATCH && !remote_pin) ? lo_q + 1 : 0;
    end
  end

  // ********
  // assertions
  // ********
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_save;
    cmd_wr && reg_wdata[3:0] == OEC_CMD_SAVE;
  endsequence

  sequence s_off;
    cmd_wr && reg_wdata[3:0] == OEC_CMD_OUT_OFF && cfg_q != OEC_PIN_HIGH_EN && cfg_q != OEC_PIN_LOW_EN;
  endsequence

  a_save_pulse: assert property (s_save |=> nv_wr == grp_q)
    else $error("save strobe does not match the chosen groups");
  a_off_cmd: assert property (s_off |=> !out_en)
    else $error("off command left the output on");
  a_high_en: assert property (ready && cfg_q == OEC_PIN_HIGH_EN |-> out_en == remote_pin)
    else $error("output does not follow a high-enabling pin");
  a_low_en: assert property (ready && cfg_q == OEC_PIN_LOW_EN |-> out_en == !remote_pin)
    else $error("output does not follow a low-enabling pin");
  a_high_dis: assert property (ready && cfg_q == OEC_PIN_HIGH_DIS && remote_pin |-> !out_en)
    else $error("high pin did not force the output off");
  a_low_dis: assert property (ready && cfg_q == OEC_PIN_LOW_DIS && !remote_pin |-> !out_en)
    else $error("low pin did not force the output off");
  // the trip lands on the edge that sees the pin low for the full count
  a_latch_trip: assert property (lo_q >= PULSE_CYC |-> !out_en)
    else $error("long low pulse did not latch the output off");
  a_iset_range: assert property (ready && reg_wr && reg_addr == OEC_ISET_OFS
    && reg_wdata[15:0] > OEC_RATED_CURRENT_CEILING
    |=> $stable(iprog))
    else $error("out of range current set-point was taken");
endmodule : oec_ctrl_monitor

bind oec_ctrl oec_ctrl_monitor #(.PULSE_CYC(PULSE_CYC)) oec_ctrl_monitor_inst (.*);
`default_nettype wire

// ===== verif/oec_ctrl_tb_top.sv
// oec_ctrl_tb_top: self-checking bench for oec_ctrl
// assumes oec_nv_model as the store and the bound monitor
`timescale 1ns/1ns
`default_nettype none
module oec_ctrl_tb_top
  import oec_pkg::*;
;
  // short trip count keeps the latched-pulse case brief
  localparam int PULSE_CYC = 8;
  logic ref_clk;
  logic rst_n;
  logic [5:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic remote_pin;
  logic [OEC_NGRP-1:0] nv_valid;
  logic [OEC_NGRP-1:0] nv_wr;
  oec_intf_grp_t nv_intf;
  oec_intf_grp_t nv_intf_w;
  oec_ser_grp_t nv_ser;
  oec_ser_grp_t nv_ser_w;
  oec_lim_grp_t nv_lim;
  oec_lim_grp_t nv_lim_w;
  oec_out_grp_t nv_out;
  oec_out_grp_t nv_out_w;
  logic out_en;
  logic analog_en;
  logic [15:0] vprog;
  logic [15:0] iprog;
  logic [15:0] iprot_pos;
  logic [15:0] iprot_neg;
  logic [15:0] vprot;
  logic ready;
  int errors;
  int cmp_count;
  logic [31:0] rv;

  oec_ctrl #(.PULSE_CYC(PULSE_CYC)) oec_ctrl_inst (.*);
  oec_nv_model oec_nv_model_inst (.*);

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ********
  // shared tasks
  // ********
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [5:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask : rd

  task automatic cmd(input logic [3:0] c);
    wr(OEC_CMD_OFS, {28'h000_0000, c});
  endtask : cmd

  // analog control bit kept set
  task automatic cfg(input logic [2:0] p, input logic [1:0] ld, input logic cm, input logic [4:0] ba);
    wr(OEC_CFG_OFS, {19'h0_0000, ba, 2'b10, ld, cm, p});
  endtask : cfg

  task automatic pin(input logic v);
    @(posedge ref_clk);
    remote_pin <= v;
    #1;
  endtask : pin

  task automatic do_reset;
    int n;
    n = 0;
    rst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    while (ready !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (ready !== 1'b1) begin
      chk("ready", 1, ready);
      complete_run;
    end
  endtask : do_reset

  // ********
  // scenarios
  // ********
  task automatic t_cmd;
    chk("out_en", 1, out_en);
    chk("analog_en", 1, analog_en);
    rd(OEC_CFG_OFS);
    chk("pin cfg", OEC_PIN_HIGH_DIS, rv[2:0]);
    cmd(OEC_CMD_OUT_OFF);
    rd(OEC_STAT_OFS);
    chk("stat off", 32'h0000_0004, rv);
    cmd(OEC_CMD_OUT_ON);
    rd(OEC_STAT_OFS);
    chk("stat on", 32'h0000_0005, rv);
    $display("t_cmd done");
  endtask : t_cmd

  task automatic t_modes;
    logic [2:0] m [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
    logic [1:0] e [5] = '{2'b01, 2'b10, 2'b01, 2'b10, 2'b11};
    for (int i = 0; i < 5; i++) begin
      cfg(m[i], 2'h0, 1'b0, 5'h00);
      rd(OEC_CFG_OFS);
      chk("pin cfg", m[i], rv[2:0]);
      for (int p = 0; p < 2; p++) begin
        pin(p[0]);
        cmd(OEC_CMD_OUT_ON);
        chk("out_en", e[i][p], out_en);
        if (m[i] == 3'h1 || m[i] == 3'h2) begin
          cmd(OEC_CMD_OUT_OFF);
          chk("out_en kept", e[i][p], out_en);
        end
      end
    end
    cfg(3'h6, 2'h0, 1'b0, 5'h00);
    rd(OEC_CFG_OFS);
    chk("pin cfg kept", 3'h5, rv[2:0]);
    $display("t_modes done");
  endtask : t_modes

  task automatic t_latch;
    cfg(OEC_PIN_LATCH, 2'h0, 1'b0, 5'h00);
    cmd(OEC_CMD_OUT_ON);
    pin(1'b0);
    repeat (PULSE_CYC - 4) @(posedge ref_clk);
    pin(1'b1);
    chk("short pulse", 1, out_en);
    pin(1'b0);
    repeat (PULSE_CYC + 4) @(posedge ref_clk);
    pin(1'b1);
    chk("tripped", 0, out_en);
    cmd(OEC_CMD_OUT_ON);
    chk("re-enabled", 1, out_en);
    $display("t_latch done");
  endtask : t_latch

  task automatic t_off;
    cfg(OEC_PIN_HIGH_DIS, 2'h1, 1'b0, 5'h00);
    pin(1'b0);
    cmd(OEC_CMD_OUT_ON);
    wr(OEC_VSET_OFS, 32'h0000_1234);
    wr(OEC_ISET_OFS, 32'h0000_0200);
    chk("iprot_pos", 16'h0200, iprot_pos);
    chk("iprot_neg", 16'h0200, iprot_neg);
    cmd(OEC_CMD_OUT_OFF);
    chk("vprog off", 16'h0000, vprog);
    chk("iprot off", OEC_LOW_PROT, iprot_pos);
    rd(OEC_VSET_OFS);
    chk("vset saved", 32'h0000_1234, rv);
    cmd(OEC_CMD_OUT_ON);
    chk("vprog on", 16'h1234, vprog);
    cfg(OEC_PIN_HIGH_DIS, 2'h2, 1'b1, 5'h00);
    rd(OEC_CFG_OFS);
    chk("load type", 2'h2, rv[5:4]);
    wr(OEC_ISET_OFS, 32'h0000_7fff);
    wr(OEC_ISET_OFS, 32'h0000_8000);
    chk("iprog kept", 16'h7fff, iprog);
    rd(OEC_ERR_OFS);
    chk("err code", OEC_ERR_RANGE, rv);
    cmd(OEC_CMD_OUT_OFF);
    chk("iprog off", 16'h0000, iprog);
    chk("vprot off", OEC_LOW_PROT, vprot);
    rd(OEC_ISET_OFS);
    chk("iset saved", 32'h0000_7fff, rv);
    cmd(OEC_CMD_OUT_ON);
    chk("iprog on", 16'h7fff, iprog);
    // active load: host goes to current mode and zero current instead of off
    cfg(OEC_PIN_HIGH_DIS, 2'h0, 1'b1, 5'h00);
    wr(OEC_ISET_OFS, 32'h0000_0000);
    chk("iprog zeroed", 16'h0000, iprog);
    chk("out_en kept on", 1, out_en);
    $display("t_off done");
  endtask : t_off

  task automatic t_save;
    cfg(OEC_PIN_LOW_DIS, 2'h0, 1'b0, 5'h0a);
    pin(1'b1);
    cmd(OEC_CMD_OUT_OFF);
    chk("vprog active off", 16'h1234, vprog);
    wr(OEC_CMD_OFS, 32'h0000_0f03);
    chk("nv_wr", 4'hf, nv_wr);
    chk("saved pin cfg", OEC_PIN_LOW_DIS, nv_intf_w.pin_cfg);
    chk("saved limits", {OEC_DEF_LIMIT, OEC_DEF_LIMIT}, nv_lim_w[63:32]);
    chk("saved out", 2'b00, nv_out_w);
    // let the store take the strobe before reset clears it
    @(posedge ref_clk);
    do_reset;
    chk("out_en reload", 0, out_en);
    rd(OEC_CFG_OFS);
    chk("addr reload", 5'h0a, rv[12:8]);
    cmd(OEC_CMD_OUT_ON);
    chk("out_en on", 1, out_en);
    $display("t_save done");
  endtask : t_save

  initial begin
    errors = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    remote_pin = 1'b0;
    do_reset;
    t_cmd;
    t_modes;
    t_latch;
    t_off;
    t_save;
    complete_run;
  end
endmodule : oec_ctrl_tb_top
`default_nettype wire

// ===== verif/oec_nv_model.sv
// oec_nv_model: behavioural nonvolatile store behind oec_ctrl
// assumes nv_wr is a one-cycle strobe per group on ref_clk
`timescale 1ns/1ns
`default_nettype none
module oec_nv_model
  import oec_pkg::*;
(
  // clock and write side
  input wire logic ref_clk,
  input wire logic [OEC_NGRP-1:0] nv_wr,
  input wire oec_intf_grp_t nv_intf_w,
  input wire oec_ser_grp_t nv_ser_w,
  input wire oec_lim_grp_t nv_lim_w,
  input wire oec_out_grp_t nv_out_w,
  // stored contents
  output var logic [OEC_NGRP-1:0] nv_valid,
  output var oec_intf_grp_t nv_intf,
  output var oec_ser_grp_t nv_ser,
  output var oec_lim_grp_t nv_lim,
  output var oec_out_grp_t nv_out
);
  // never-saved groups read all ones, so ignoring nv_valid shows up
  initial begin
    nv_valid = '0;
    nv_intf = '1;
    nv_ser = '1;
    nv_lim = '1;
    nv_out = '1;
  end

  // contents outlive rst_n on purpose
  always @(posedge ref_clk) begin
    nv_valid <= nv_valid | nv_wr;
    if (nv_wr[OEC_GRP_INT]) nv_intf <= nv_intf_w;
    if (nv_wr[OEC_GRP_SER]) nv_ser <= nv_ser_w;
    if (nv_wr[OEC_GRP_LIM]) nv_lim <= nv_lim_w;
    if (nv_wr[OEC_GRP_OUT]) nv_out <= nv_out_w;
  end
endmodule : oec_nv_model
`default_nettype wire
